// *** common/slpd_pkg.sv ***
package slpd_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned BLINK_HZ = 1;
	// half period of the blink, in clock cycles
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned CODE_W = 8;
	localparam logic [7:0] CODE_RST = 8'h00;

	// ==========================================
	// severity classes, most severe last
	typedef enum logic [2:0] {
		SLPD_DARK,
		SLPD_OK,
		SLPD_DEGRADED,
		SLPD_NONFATAL,
		SLPD_FATAL
	} slpd_sev_t;

	// ==========================================
	// alarm inputs grouped by class
	typedef struct packed {
		logic cpuCatastrophicError;
		logic processorIdMismatch;
		logic cpu1Absent;
		logic cpuThermalShutdownTrip;
		logic powerGoodFault;
		logic memThermalShutdownTrip;
		logic southbridgeThermalShutdownTrip;
		logic cpuErrorLevel2;
		logic fault240va;
		logic mgmtVideoMemTestFail;
		logic mgmtBootLoaderImagesBad;
	} slpd_fatal_t;

	typedef struct packed {
		logic criticalThreshold;
		logic regulatorHot;
		logic fansBelowMinimum;
		logic memNoSpareNoMirror;
		logic memCorrErrOverThreshold;
		logic driveFault;
		logic powerSuppliesInsufficient;
	} slpd_nonfatal_t;

	typedef struct packed {
		logic redundancyLost;
		logic nonCriticalThreshold;
		logic otherDegraded;
	} slpd_degraded_t;

	typedef struct packed {
		logic green;
		logic amber;
	} slpd_led_t;
endpackage : slpd_pkg

// *** rtl/slpd_blinker.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// free running square wave at the blink rate
module slpd_blinker #(
	parameter int unsigned HALF_CYC = slpd_pkg::BLINK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	output logic blinkPhase
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic phase_r;
	logic phase_nxt;

	always_comb begin
		cnt_nxt = cnt_r + 32'h1;
		phase_nxt = phase_r;
		if (cnt_r >= HALF_CYC - 1) begin
			cnt_nxt = 32'h0;
			phase_nxt = ~phase_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_r <= 32'h0;
			phase_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	assign blinkPhase = phase_r;
endmodule : slpd_blinker
`default_nettype wire

// *** rtl/slpd_status_led.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - one colour and one pattern at once
// - healthy and management up: solid green
// - degraded conditions only: green blink 1 Hz
// - non-fatal alarm inputs: amber blink 1 Hz
// - unspared memory error threshold: amber blink
// - drive fault, supplies short: amber blink
// - fatal inputs: solid amber
// - processor id mismatch: solid amber
// - mgmt memory/images bad: amber, identify blue
// - power-down keeps indicator and sensor state
// - solid green at power-down turns LED off
// - written code latched onto LEDs at the next clock edge
// - code held until next write
// - LED 7 is MSB, LED 0 LSB
module slpd_status_led #(
	parameter int unsigned BLINK_HALF_CYC = slpd_pkg::BLINK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic acPowerPresent,
	input wire logic mgmtOperational,
	input wire logic systemPoweredDown,
	input wire slpd_pkg::slpd_fatal_t fatalIn,
	input wire slpd_pkg::slpd_nonfatal_t nonFatalIn,
	input wire slpd_pkg::slpd_degraded_t degradedIn,
	input wire logic codeWrite,
	input wire logic [slpd_pkg::CODE_W-1:0] codeData,
	output slpd_pkg::slpd_led_t statusLed,
	output logic identifyBlueOn,
	output logic [slpd_pkg::CODE_W-1:0] diagLed
);
	// ==========================================
	// class decode
	logic isFatal;
	logic isNonFatal;
	logic isDegraded;
	logic blinkPhase;
	slpd_pkg::slpd_sev_t liveSev;
	slpd_pkg::slpd_sev_t sev_r;
	slpd_pkg::slpd_sev_t sev_nxt;
	logic ident_r;
	logic ident_nxt;
	logic [slpd_pkg::CODE_W-1:0] code_r;
	logic [slpd_pkg::CODE_W-1:0] code_nxt;
	slpd_pkg::slpd_led_t led_r;
	slpd_pkg::slpd_led_t led_nxt;

	slpd_blinker #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
		.core_clk(core_clk),
		.srst(srst),
		.blinkPhase(blinkPhase)
	);

	always_comb begin
		isFatal = |fatalIn;
		isNonFatal = nonFatalIn.criticalThreshold | nonFatalIn.regulatorHot
			| nonFatalIn.fansBelowMinimum | nonFatalIn.driveFault
			| nonFatalIn.powerSuppliesInsufficient;
		// error count only matters when memory has no spare or mirror
		isNonFatal = isNonFatal
			| (nonFatalIn.memNoSpareNoMirror & nonFatalIn.memCorrErrOverThreshold);
		isDegraded = |degradedIn | ~mgmtOperational;
		// priority chain picks exactly one class
		if (isFatal) begin
			liveSev = slpd_pkg::SLPD_FATAL;
		end else if (isNonFatal) begin
			liveSev = slpd_pkg::SLPD_NONFATAL;
		end else if (isDegraded) begin
			liveSev = slpd_pkg::SLPD_DEGRADED;
		end else begin
			liveSev = slpd_pkg::SLPD_OK;
		end
	end

	// ==========================================
	// indicator state
	always_comb begin
		sev_nxt = sev_r;
		ident_nxt = ident_r;
		if (!acPowerPresent) begin
			sev_nxt = slpd_pkg::SLPD_DARK;
			ident_nxt = 1'b0;
		end else if (systemPoweredDown) begin
			// frozen on standby power; a healthy state goes dark instead
			if (sev_r == slpd_pkg::SLPD_OK) begin
				sev_nxt = slpd_pkg::SLPD_DARK;
			end
		end else begin
			sev_nxt = liveSev;
			ident_nxt = fatalIn.mgmtVideoMemTestFail | fatalIn.mgmtBootLoaderImagesBad;
		end
	end

	always_comb begin
		led_nxt = '0;
		unique case (sev_nxt)
			slpd_pkg::SLPD_DARK: led_nxt = '0;
			slpd_pkg::SLPD_OK: led_nxt.green = 1'b1;
			slpd_pkg::SLPD_DEGRADED: led_nxt.green = blinkPhase;
			slpd_pkg::SLPD_NONFATAL: led_nxt.amber = blinkPhase;
			slpd_pkg::SLPD_FATAL: led_nxt.amber = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sev_r <= slpd_pkg::SLPD_DARK;
			ident_r <= 1'b0;
			led_r <= '0;
		end else begin
			sev_r <= sev_nxt;
			ident_r <= ident_nxt;
			led_r <= led_nxt;
		end
	end

	// ==========================================
	// progress code display
	always_comb begin
		code_nxt = code_r;
		if (codeWrite) begin
			code_nxt = codeData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			code_r <= slpd_pkg::CODE_RST;
		end else begin
			code_r <= code_nxt;
		end
	end

	assign statusLed = led_r;
	assign identifyBlueOn = ident_r;
	// bit 7 drives LED 7, bit 0 drives LED 0
	assign diagLed = code_r;
endmodule : slpd_status_led
`default_nettype wire

// *** bench/slpd_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checker
module slpd_monitor (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic acPowerPresent,
	input wire logic mgmtOperational,
	input wire logic systemPoweredDown,
	input wire slpd_pkg::slpd_fatal_t fatalIn,
	input wire slpd_pkg::slpd_nonfatal_t nonFatalIn,
	input wire slpd_pkg::slpd_degraded_t degradedIn,
	input wire logic codeWrite,
	input wire logic [7:0] codeData,
	input wire slpd_pkg::slpd_led_t statusLed,
	input wire logic identifyBlueOn,
	input wire logic [7:0] diagLed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire logic live = acPowerPresent && !systemPoweredDown;
	wire logic fat = |fatalIn;
	wire logic nf = |nonFatalIn[6:4] || |nonFatalIn[1:0] || &nonFatalIn[3:2];
	wire logic dg = |degradedIn || !mgmtOperational;
	wire logic idc = |fatalIn[1:0];
	a_one_colour: assert property (!(statusLed.green && statusLed.amber)) else $error("both");
	a_ok_green: assert property (live && !fat && !nf && !dg |=> statusLed == 2'h2) else $error("ok");
	a_deg_green: assert property (live && !fat && !nf && dg |=> !statusLed.amber) else $error("deg");
	a_nf_amber: assert property (live && !fat && nf |=> !statusLed.green) else $error("nf");
	a_fatal_solid: assert property (live && fat |=> statusLed == 2'h1) else $error("fat");
	a_id_blue: assert property (live |=> identifyBlueOn == $past(idc)) else $error("id");
	a_ac_dark: assert property (!acPowerPresent |=> statusLed == 2'h0 && !identifyBlueOn) else $error("ac");
	a_code_load: assert property (codeWrite |=> diagLed == $past(codeData)) else $error("load");
	a_code_hold: assert property (!codeWrite |=> $stable(diagLed)) else $error("hold");
	c_fatal_id: cover property (statusLed.amber && identifyBlueOn);
	c_blink: cover property ($rose(statusLed.green));
	c_write: cover property (codeWrite);
endmodule : slpd_monitor
bind slpd_status_led slpd_monitor u_mon (.*);
`default_nettype wire

// *** bench/slpd_fw_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// firmware writing progress codes at random steps
module slpd_fw_model (
	input wire logic core_clk,
	input wire logic srst,
	output logic codeWrite = 1'b0,
	output logic [slpd_pkg::CODE_W-1:0] codeData = 8'h00
);
	logic [7:0] s = 8'h0f;
	// maximal taps, so each step gets its own code
	function automatic logic [7:0] lfsr(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	always @(posedge core_clk) begin
		s <= lfsr(s);
		codeWrite <= !srst && s[0];
		codeData <= s;
	end
endmodule : slpd_fw_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %h", $time, a); end end
module tb_top;
	logic core_clk = 0, srst = 1, ac = 1, pd = 0, mg = 1, cw, id;
	logic [7:0] cd, dl;
	logic [10:0] f = 0;
	logic [6:0] n = 0;
	logic [2:0] d = 0;
	logic [5:0] x;
	slpd_pkg::slpd_led_t led;
	int error_cnt = 0, n_checks = 0, blinks;
	logic [5:0] q[$];
	logic [7:0] qd[$];
	always #10 core_clk = ~core_clk;
	slpd_status_led #(.BLINK_HALF_CYC(4)) uut (.core_clk, .srst, .acPowerPresent(ac),
		.mgmtOperational(mg), .systemPoweredDown(pd), .fatalIn(f), .nonFatalIn(n),
		.degradedIn(d), .codeWrite(cw), .codeData(cd), .statusLed(led),
		.identifyBlueOn(id), .diagLed(dl));
	slpd_fw_model fw (.core_clk, .srst, .codeWrite(cw), .codeData(cd));
	// ==========================================
	// x holds care mask then {green, amber, blue}
	task automatic ap(logic a, p, logic [10:0] ff, logic [6:0] nn, logic [2:0] dd, logic [5:0] e);
		@(posedge core_clk);
		ac <= a;
		pd <= p;
		f <= ff;
		n <= nn;
		d <= dd;
		@(posedge core_clk);
		q.push_back(e);
	endtask : ap
	always @(posedge core_clk) if (!srst && cw) qd.push_back(cd);
	always @(negedge core_clk) begin
		if (q.size()) begin
			x = q.pop_front();
			`CHK({led, id} & x[5:3], x[2:0])
		end
		if (qd.size()) `CHK(dl, qd.pop_front())
	end
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 0;
		ap(1, 0, 0, 0, 0, 6'h3c);
		for (int i = 0; i < 11; i++) ap(1, 0, 11'h1 << i, 7'h7f, 3'h7, {5'h1d, i < 2});
		for (int i = 0; i < 8; i++) ap(1, 0, 0, i < 7 ? 7'h1 << i : 7'h0c, 3'h7, {i == 2 || i == 3 ? 3'h3 : 3'h5, 3'h0});
		// steady alarm over two blink periods must be lit exactly half the time
		ap(1, 0, 0, 7'h40, 0, 6'h28);
		blinks = 0;
		repeat (16) begin
			@(negedge core_clk);
			blinks += led.amber;
		end
		`CHK(blinks, 32'd8)
		ap(1, 0, 0, 0, 3'h1, 6'h18);
		blinks = 0;
		repeat (16) begin
			@(negedge core_clk);
			blinks += led.green;
		end
		`CHK(blinks, 32'd8)
		mg <= 0;
		ap(1, 0, 0, 0, 0, 6'h18);
		mg <= 1;
		for (int i = 0; i < 3; i++) ap(1, 0, 0, 0, 3'h1 << i, 6'h18);
		ap(1, 0, 0, 0, 0, 6'h3c);
		ap(1, 1, 0, 0, 0, 6'h38);
		ap(1, 0, 11'h4, 0, 0, 6'h3a);
		ap(1, 1, 0, 0, 0, 6'h3a);
		ap(0, 0, 11'h7ff, 0, 0, 6'h38);
		ap(1, 0, 0, 0, 0, 6'h3c);
		repeat (3) @(posedge core_clk);
		summarize();
	end
	initial begin
		#100us;
		error_cnt++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
